// ---- verif/frp_control_asserts.sv ----
/* Port checker for the flash rewrite protect controller.
 Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module frp_control_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [23:0] resetVector,
	input wire logic codeProtectEn,
	input wire logic cmdValid,
	input wire frp_pkg::frp_cmd_type cmd,
	input wire logic [3:0] dataBlockProtect,
	input wire logic arrayBusy,
	input wire logic cmdAccepted,
	input wire logic cmdRejected,
	input wire frp_pkg::frp_array_req_type arrayReq,
	input wire logic arrayReqValid,
	input wire logic idCheckActive,
	input wire logic idCheckPassed,
	input wire logic [3:0] lockBits,
	input wire frp_pkg::frp_mode_type rewriteMode
);
	wire logic known = cmd.code inside {8'hFF, 8'h70, 8'h50, 8'h40, 8'h20, 8'h77, 8'h71, 8'h25};
	wire logic arrOp = cmd.code inside {8'h40, 8'h20, 8'h77};
	wire logic ser = rewriteMode == frp_pkg::FRP_MODE_SERIAL;
	wire logic pgm = cmdValid && cmd.code == 8'h40;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_unknown;
		cmdValid && !known |=> !cmdAccepted && !cmdRejected;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown code answered");
	property p_busy;
		cmdValid && arrOp && arrayBusy |=> cmdRejected && !arrayReqValid;
	endproperty
	a_busy: assert property (p_busy) else $error("busy array not refused");
	property p_lock;
		pgm && !cmd.block[2] && lockBits[cmd.block[1:0]] |=> cmdRejected;
	endproperty
	a_lock: assert property (p_lock) else $error("locked block written");
	property p_dprot;
		pgm && cmd.block[2] && dataBlockProtect[cmd.block[1:0]] |=> cmdRejected;
	endproperty
	a_dprot: assert property (p_dprot) else $error("protected block written");
	property p_idfail;
		cmdValid && known && ser && resetVector != 24'hFF_FFFF && !idCheckPassed |=> cmdRejected;
	endproperty
	a_idfail: assert property (p_idfail) else $error("command without id");
	property p_blank;
		ser && resetVector == 24'hFF_FFFF |-> !idCheckActive;
	endproperty
	a_blank: assert property (p_blank) else $error("id check on blank vector");
	property p_parprot;
		cmdValid && known && rewriteMode == frp_pkg::FRP_MODE_PARALLEL && codeProtectEn |=> cmdRejected;
	endproperty
	a_parprot: assert property (p_parprot) else $error("code protect ignored");
	property p_prog;
		arrayReqValid && arrayReq.op == frp_pkg::FRP_OP_PROGRAM |-> arrayReq.data == $past(cmd.data);
	endproperty
	a_prog: assert property (p_prog) else $error("program byte wrong");
endmodule
bind frp_control frp_control_asserts u_chk (.sys_clk, .nrst, .resetVector, .codeProtectEn,
	.cmdValid, .cmd, .dataBlockProtect, .arrayBusy, .cmdAccepted, .cmdRejected, .arrayReq,
	.arrayReqValid, .idCheckActive, .idCheckPassed, .lockBits, .rewriteMode);
`default_nettype wire

// ---- verif/frp_prog_model.sv ----
/* Serial programmer model: sends a seven-byte ID when asked.
 Assumes it shares the controller's system clock. */
`timescale 1ns/10ps
`default_nettype none
module frp_prog_model (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [55:0] idIn,
	output logic idByteValid,
	output logic [7:0] idByteData
);
	int left = 0;
	initial begin
		idByteValid = 1'b0;
		idByteData = 8'h00;
	end
	always @(negedge sys_clk) begin
		if (left != 0) begin
			idByteValid <= 1'b1;
			idByteData <= idIn[8*(7-left) +: 8];
			left <= left - 1;
		end else begin
			idByteValid <= 1'b0;
			// An idle line must not keep showing the last byte.
			idByteData <= ~idByteData;
		end
		if (go) begin
			left <= 7;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_flash_rewrite_protect_control.sv ----
/* Self-checking bench for the flash rewrite protect controller.
 Assumes the checker is bound and the programmer model is present. */
`timescale 1ns/10ps
`default_nettype none
module tb_flash_rewrite_protect_control;
	logic sys_clk = 1'b0, nrst = 1'b0, serialBootPin = 1'b0, parallelModePin = 1'b0;
	logic codeProtectEn = 1'b0, cmdValid = 1'b0, arrayBusy = 1'b0, go = 1'b0;
	logic [23:0] resetVector = 24'h12_3456;
	logic [55:0] storedId = 56'h11_2233_4455_6677, idIn = 56'h0;
	logic [3:0] dataBlockProtect = 4'h0;
	frp_pkg::frp_cmd_type cmd = '0;
	logic cmdAccepted, cmdRejected, arrayReqValid, idByteValid, idCheckActive, idCheckPassed;
	logic parallelReadEn, bootRomSelect;
	logic [7:0] idByteData;
	logic [3:0] lockBits;
	frp_pkg::frp_array_req_type arrayReq;
	frp_pkg::frp_mode_type rewriteMode;
	logic [7:0] codes [8] = '{8'hFF, 8'h70, 8'h50, 8'h40, 8'h20, 8'h71, 8'h25, 8'h77};
	int errors = 0;
	int checks_done = 0;
	frp_control dut (.sys_clk, .nrst, .serialBootPin, .parallelModePin, .resetVector, .storedId,
		.codeProtectEn, .idByteValid, .idByteData, .cmdValid, .cmd, .dataBlockProtect, .arrayBusy,
		.cmdAccepted, .cmdRejected, .arrayReq, .arrayReqValid, .parallelReadEn, .bootRomSelect,
		.idCheckActive, .idCheckPassed, .lockBits, .rewriteMode);
	frp_prog_model pm (.sys_clk, .go, .idIn, .idByteValid, .idByteData);
	initial forever #4 sys_clk = ~sys_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task op(input logic [7:0] c, input logic [2:0] b, input logic ea, input logic er);
		@(negedge sys_clk);
		cmdValid = 1'b1;
		cmd = {c, b, 20'h0_0100, 8'h5A};
		@(negedge sys_clk);
		cmdValid = 1'b0;
		chk(cmdAccepted, ea);
		chk(cmdRejected, er);
		chk(arrayReqValid, ea && c inside {8'h40, 8'h20, 8'h77});
	endtask
	task wmode(input frp_pkg::frp_mode_type m);
		int n;
		n = 0;
		while (rewriteMode !== m && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk(rewriteMode, m);
		// A mode that never arrives has already been counted as a mismatch.
		if (rewriteMode !== m) results();
	endtask
	task sendId(input logic [55:0] id, input logic exp);
		int n;
		n = 0;
		@(negedge sys_clk);
		idIn = id;
		go <= 1'b1;
		@(negedge sys_clk);
		go <= 1'b0;
		while (idCheckActive !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk(idCheckActive, 1'b0);
		chk(idCheckPassed, exp);
		if (idCheckActive !== 1'b0) results();
	endtask
	task t_cpu;
		chk(rewriteMode, frp_pkg::FRP_MODE_CPU);
		chk(lockBits, 4'h0);
		chk(bootRomSelect, 1'b0);
		chk(parallelReadEn, 1'b0);
		op(8'h20, 3'h0, 1, 0);
		chk(arrayReq.op, frp_pkg::FRP_OP_ERASE);
		chk(arrayReq.data, 8'h00);
		chk(arrayReq.addr, 20'h0_0000);
		op(8'h00, 3'h4, 0, 0);
		for (int i = 0; i < 8; i++) begin
			op(codes[i], 3'h0, 1, 0);
		end
		chk(lockBits, 4'h1);
		op(8'h40, 3'h0, 0, 1);
		op(8'h40, 3'h2, 1, 0);
		chk(arrayReq.data, 8'h5A);
		arrayBusy = 1'b1;
		op(8'h40, 3'h2, 0, 1);
		arrayBusy = 1'b0;
		$display("cpu test done");
	endtask
	task t_prot;
		for (int i = 0; i < 4; i++) begin
			dataBlockProtect = 4'h1 << i;
			op(8'h40, 3'(4 + i), 0, 1);
			op(8'h40, 3'(4 + (i + 1) % 4), 1, 0);
		end
		dataBlockProtect = 4'h0;
		$display("protect test done");
	endtask
	task t_serial;
		serialBootPin = 1'b1;
		wmode(frp_pkg::FRP_MODE_SERIAL);
		chk(idCheckActive, 1);
		chk(bootRomSelect, 1'b1);
		sendId(56'h11_2233_4455_6676, 0);
		op(8'h70, 3'h0, 0, 1);
		serialBootPin = 1'b0;
		wmode(frp_pkg::FRP_MODE_CPU);
		serialBootPin = 1'b1;
		wmode(frp_pkg::FRP_MODE_SERIAL);
		sendId(storedId, 1);
		op(8'h40, 3'h5, 1, 0);
		serialBootPin = 1'b0;
		wmode(frp_pkg::FRP_MODE_CPU);
		resetVector = frp_pkg::VEC_BLANK;
		serialBootPin = 1'b1;
		wmode(frp_pkg::FRP_MODE_SERIAL);
		chk(idCheckActive, 0);
		op(8'h40, 3'h5, 1, 0);
		serialBootPin = 1'b0;
		wmode(frp_pkg::FRP_MODE_CPU);
		resetVector = 24'h12_3456;
		$display("serial test done");
	endtask
	task t_par;
		parallelModePin = 1'b1;
		codeProtectEn = 1'b1;
		wmode(frp_pkg::FRP_MODE_PARALLEL);
		chk(parallelReadEn, 1'b0);
		chk(bootRomSelect, 1'b0);
		op(8'h40, 3'h4, 0, 1);
		codeProtectEn = 1'b0;
		op(8'h40, 3'h4, 1, 0);
		chk(parallelReadEn, 1'b1);
		parallelModePin = 1'b0;
		wmode(frp_pkg::FRP_MODE_CPU);
		$display("parallel test done");
	endtask
	initial begin
		repeat (12) @(negedge sys_clk);
		nrst = 1'b1;
		t_cpu();
		t_prot();
		t_serial();
		t_par();
		results();
	end
endmodule
`default_nettype wire

// ---- verilog/frp_control.sv ----
/*
 * Flash rewrite protect control: selects the rewrite mode, decodes commands,
 * applies lock bits, data-flash protect bits, serial ID check and parallel
 * code protect, and issues program or erase requests to the flash array.
 * Assumes the array macro performs the operation and the reset vector bytes
 * and stored ID are presented by the array read path.
 */
// Summary of operation
// R1: Three rewrite modes exist: CPU, standard serial, parallel.
// R2: Program and erase start only from a decoded software command.
// R3: Each program ROM block has a lock bit blocking its rewrite.
// R4: Each of four data flash blocks has its own protect bit.
// R5: User ROM holds program ROM and data flash in erasable blocks.
// R6: User ROM is rewritable in any of the three modes.
// R7: Boot ROM is separate and serves the serial mode.
// R8: CPU mode rewrites via processor commands, no external programmer.
// R9: Serial ID check skipped only when reset vector bytes are all FFh.
// R10: Programmer sends an ID compared with the stored seven-byte code.
// R11: After an ID mismatch all serial commands are rejected; codes outside the eight get neither accept nor reject.
// R12: Parallel code protect blocks parallel reads and rewrites.
// R13: Program writes one byte; erase clears a whole block.
// R14: Only the eight known command codes are acted on.
`timescale 1ns/10ps
`default_nettype none
module frp_control (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic serialBootPin,
	input wire logic parallelModePin,
	input wire logic [23:0] resetVector,
	input wire logic [frp_pkg::ID_BYTES*8-1:0] storedId,
	input wire logic codeProtectEn,
	input wire logic idByteValid,
	input wire logic [7:0] idByteData,
	input wire logic cmdValid,
	input wire frp_pkg::frp_cmd_type cmd,
	input wire logic [frp_pkg::DATA_BLOCKS-1:0] dataBlockProtect,
	input wire logic arrayBusy,
	output logic cmdAccepted,
	output logic cmdRejected,
	output frp_pkg::frp_array_req_type arrayReq,
	output logic arrayReqValid,
	output logic parallelReadEn,
	output logic bootRomSelect,
	output logic idCheckActive,
	output logic idCheckPassed,
	output logic [frp_pkg::PROG_BLOCKS-1:0] lockBits,
	output frp_pkg::frp_mode_type rewriteMode
);

	logic [2:0] bootSync_r;
	logic [2:0] parSync_r;
	logic boot_r;
	logic boot_nxt;
	logic par_r;
	logic par_nxt;
	frp_pkg::frp_mode_type mode_r;
	frp_pkg::frp_mode_type mode_nxt;
	logic [frp_pkg::PROG_BLOCKS-1:0] lock_r;
	logic [frp_pkg::PROG_BLOCKS-1:0] lock_nxt;
	frp_pkg::frp_array_req_type req_r;
	frp_pkg::frp_array_req_type req_nxt;
	logic reqValid_r;
	logic reqValid_nxt;
	logic acc_r;
	logic acc_nxt;
	logic rej_r;
	logic rej_nxt;
	logic modeChange;
	logic idNeeded;
	logic idDone;
	logic idMatch;
	logic serialOpen;
	logic blockWritable;
	frp_pkg::frp_op_type op;

	// R14: fixed command set
	function automatic frp_pkg::frp_op_type decode_op(input logic [7:0] code);
		unique case (code)
			frp_pkg::CMD_PROGRAM: decode_op = frp_pkg::FRP_OP_PROGRAM;
			frp_pkg::CMD_BLOCK_ERASE: decode_op = frp_pkg::FRP_OP_ERASE;
			frp_pkg::CMD_LOCK_BIT_PGM: decode_op = frp_pkg::FRP_OP_LOCK;
			default: decode_op = frp_pkg::FRP_OP_NONE;
		endcase
	endfunction

	function automatic logic is_known(input logic [7:0] code);
		is_known = (code == frp_pkg::CMD_READ_ARRAY) || (code == frp_pkg::CMD_READ_STATUS)
			|| (code == frp_pkg::CMD_CLEAR_STATUS) || (code == frp_pkg::CMD_PROGRAM)
			|| (code == frp_pkg::CMD_BLOCK_ERASE) || (code == frp_pkg::CMD_LOCK_BIT_PGM)
			|| (code == frp_pkg::CMD_LOCK_BIT_READ) || (code == frp_pkg::CMD_BLANK_CHECK);
	endfunction

	// Mode pins come from outside; three stages, change taken when stages two and three agree.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bootSync_r <= 3'h0;
			parSync_r <= 3'h0;
		end else begin
			bootSync_r <= {bootSync_r[1:0], serialBootPin};
			parSync_r <= {parSync_r[1:0], parallelModePin};
		end
	end

	always_comb begin
		boot_nxt = (bootSync_r[2] == bootSync_r[1]) ? bootSync_r[2] : boot_r;
		par_nxt = (parSync_r[2] == parSync_r[1]) ? parSync_r[2] : par_r;
		// R1: three rewrite modes
		if (par_r) begin
			mode_nxt = frp_pkg::FRP_MODE_PARALLEL;
		end else if (boot_r) begin
			mode_nxt = frp_pkg::FRP_MODE_SERIAL;
		end else begin
			// R8: CPU drives commands
			mode_nxt = frp_pkg::FRP_MODE_CPU;
		end
	end

	assign modeChange = (mode_nxt != mode_r);

	// R9: blank reset vector skips check
	assign idNeeded = (mode_r == frp_pkg::FRP_MODE_SERIAL) && (resetVector != frp_pkg::VEC_BLANK);

	frp_id_check idCheck (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.restart(modeChange),
		.byteValid(idByteValid && idNeeded),
		.byteData(idByteData),
		.storedId(storedId),
		.done(idDone),
		.match(idMatch)
	);

	// R11: mismatch rejects commands
	assign serialOpen = !idNeeded || idMatch;

	// R3: per-block lock; R4: per-block data protect; R5: block layout
	always_comb begin
		if (cmd.block >= frp_pkg::BLK_DATA_A) begin
			blockWritable = !dataBlockProtect[cmd.block[1:0]];
		end else begin
			blockWritable = !lock_r[cmd.block[1:0]];
		end
	end

	assign op = decode_op(cmd.code);

	always_comb begin
		lock_nxt = lock_r;
		req_nxt = req_r;
		reqValid_nxt = 1'b0;
		acc_nxt = 1'b0;
		rej_nxt = 1'b0;
		if (cmdValid) begin
			if (!is_known(cmd.code)) begin
				rej_nxt = 1'b0;
			end else if (mode_r == frp_pkg::FRP_MODE_SERIAL && !serialOpen) begin
				rej_nxt = 1'b1;
			end else if (mode_r == frp_pkg::FRP_MODE_PARALLEL && codeProtectEn) begin
				// R12: parallel code protect
				rej_nxt = 1'b1;
			end else if (op == frp_pkg::FRP_OP_NONE) begin
				acc_nxt = 1'b1;
			end else if (arrayBusy || (op != frp_pkg::FRP_OP_LOCK && !blockWritable)) begin
				rej_nxt = 1'b1;
			end else begin
				// R2: command starts operation; R6: any mode
				acc_nxt = 1'b1;
				reqValid_nxt = 1'b1;
				req_nxt.op = op;
				req_nxt.block = cmd.block;
				// R13: byte program, block erase
				req_nxt.addr = (op == frp_pkg::FRP_OP_PROGRAM) ? cmd.addr : '0;
				req_nxt.data = (op == frp_pkg::FRP_OP_PROGRAM) ? cmd.data : 8'h00;
				if (op == frp_pkg::FRP_OP_LOCK && cmd.block < frp_pkg::BLK_DATA_A) begin
					lock_nxt[cmd.block[1:0]] = 1'b1;
				end
				if (op == frp_pkg::FRP_OP_ERASE && cmd.block < frp_pkg::BLK_DATA_A) begin
					lock_nxt[cmd.block[1:0]] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_r <= 1'b0;
			par_r <= 1'b0;
			mode_r <= frp_pkg::FRP_MODE_CPU;
			lock_r <= '0;
			req_r <= '0;
			reqValid_r <= 1'b0;
			acc_r <= 1'b0;
			rej_r <= 1'b0;
		end else begin
			boot_r <= boot_nxt;
			par_r <= par_nxt;
			mode_r <= mode_nxt;
			lock_r <= lock_nxt;
			req_r <= req_nxt;
			reqValid_r <= reqValid_nxt;
			acc_r <= acc_nxt;
			rej_r <= rej_nxt;
		end
	end

	assign cmdAccepted = acc_r;
	assign cmdRejected = rej_r;
	assign arrayReq = req_r;
	assign arrayReqValid = reqValid_r;
	// R12: parallel read blocked
	assign parallelReadEn = (mode_r == frp_pkg::FRP_MODE_PARALLEL) && !codeProtectEn;
	// R7: boot ROM serves serial mode
	assign bootRomSelect = (mode_r == frp_pkg::FRP_MODE_SERIAL);
	assign idCheckActive = idNeeded && !idDone;
	assign idCheckPassed = serialOpen && (mode_r == frp_pkg::FRP_MODE_SERIAL);
	assign lockBits = lock_r;
	assign rewriteMode = mode_r;

endmodule
`default_nettype wire

// ---- verilog/frp_id_check.sv ----
/*
 * Serial-mode ID code comparator: takes seven received bytes in order and
 * compares them with the stored code, reporting pass or fail once complete.
 * Assumes bytes arrive as single-cycle strobes on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module frp_id_check (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic restart,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic [frp_pkg::ID_BYTES*8-1:0] storedId,
	output logic done,
	output logic match
);

	logic [2:0] count_r;
	logic [2:0] count_nxt;
	logic ok_r;
	logic ok_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		count_nxt = count_r;
		ok_nxt = ok_r;
		done_nxt = done_r;
		if (restart) begin
			count_nxt = 3'h0;
			ok_nxt = 1'b1;
			done_nxt = 1'b0;
		end else if (byteValid && !done_r) begin
			// R10: bytewise ID compare
			if (byteData != storedId[count_r*8 +: 8]) begin
				ok_nxt = 1'b0;
			end
			if (count_r == 3'(frp_pkg::ID_BYTES - 1)) begin
				done_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_r <= 3'h0;
			ok_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			ok_r <= ok_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign match = done_r && ok_r;

endmodule
`default_nettype wire

// ---- verilog/frp_pkg.sv ----
/*
 * Shared constants and carrier types for the flash rewrite protect control block.
 * Assumes a single 125 MHz clock domain and no register bus; all controls are ports.
 */
package frp_pkg;

	localparam int PROG_BLOCKS = 4;
	localparam int DATA_BLOCKS = 4;
	localparam int ID_BYTES = 7;
	localparam int ADDR_W = 20;
	localparam int BLK_W = 3;

	// Reset vector bytes checked for the blank state.
	localparam logic [ADDR_W-1:0] VEC_LO_ADDR = 20'h0_FFFC;
	localparam logic [ADDR_W-1:0] VEC_HI_ADDR = 20'h0_FFFE;
	localparam logic [23:0] VEC_BLANK = 24'hFF_FFFF;

	// Block index encoding: 0..3 program ROM, 4..7 data flash A..D.
	localparam logic [BLK_W-1:0] BLK_DATA_A = 3'h4;

	// Command codes, eight in all.
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_LOCK_BIT_PGM = 8'h77;
	localparam logic [7:0] CMD_LOCK_BIT_READ = 8'h71;
	localparam logic [7:0] CMD_BLANK_CHECK = 8'h25;

	typedef enum logic [1:0] {
		FRP_MODE_CPU,
		FRP_MODE_SERIAL,
		FRP_MODE_PARALLEL,
		FRP_MODE_NONE
	} frp_mode_type;

	typedef enum logic [1:0] {
		FRP_OP_NONE,
		FRP_OP_PROGRAM,
		FRP_OP_ERASE,
		FRP_OP_LOCK
	} frp_op_type;

	typedef struct packed {
		logic [7:0] code;
		logic [BLK_W-1:0] block;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} frp_cmd_type;

	typedef struct packed {
		frp_op_type op;
		logic [BLK_W-1:0] block;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} frp_array_req_type;

endpackage
